/* src/rps_pkg.sv */
// Purpose: Shared constants and types for the radio power sequencer.
// Assumes: 40 MHz system clock; registers reached over AXI4-Lite.
// Notes: Register indices are kept as printed; byte address is four times the index.
package rps_pkg;

    // Register indices and address width.
    localparam logic [15:0] IDX_PWR    = 16'hDF17;
    localparam logic [15:0] IDX_TIM_H  = 16'hDF20;
    localparam logic [15:0] IDX_TIM_L  = 16'hDF21;
    localparam logic [15:0] IDX_MASK_H = 16'hDF22;
    localparam logic [15:0] IDX_MASK_L = 16'hDF23;
    localparam int          ADDR_BITS  = 18;

    // Field positions.
    localparam int PWR_FLAG_BIT = 4;
    localparam int PWR_OFF_BIT  = 3;
    localparam int PWR_CODE_LSB = 0;
    localparam int RXD_LSB      = 5;
    localparam int SWL_LSB      = 2;
    localparam int AMPH_LSB     = 0;
    localparam int AMPL_LSB     = 6;
    localparam int SWG_LSB      = 3;
    localparam int AMPG_LSB     = 0;
    localparam int MH_VGARST    = 7;
    localparam int MH_BIAS      = 6;
    localparam int MH_BALUN     = 5;
    localparam int MH_RXTX      = 4;
    localparam int MH_PRE       = 3;
    localparam int MH_PAN       = 2;
    localparam int MH_PAP       = 1;
    localparam int MH_DAC       = 0;
    localparam int ML_CAL       = 6;
    localparam int ML_CHP       = 5;
    localparam int ML_FS        = 4;
    localparam int ML_ADC       = 3;
    localparam int ML_VGA       = 2;
    localparam int ML_BPF       = 1;
    localparam int ML_LNA       = 0;

    // Reset values.
    localparam logic       RST_OFF    = 1'b1;
    localparam logic       RST_FLAG   = 1'b1;
    localparam logic [2:0] RST_CODE   = 3'h4;
    localparam logic [7:0] RST_TIM_H  = 8'h7A;
    localparam logic [7:0] RST_TIM_L  = 8'h94;
    localparam logic [7:0] RST_MASK_H = 8'hFF;
    localparam logic [6:0] RST_MASK_L = 7'h7F;

    // Timing.
    localparam int          CLK_PERIOD_PS    = 25000;
    localparam int          US_PS            = 1000000;
    localparam int          CYC_PER_US       = US_PS / CLK_PERIOD_PS;
    localparam logic [11:0] RX_STEP_US       = 12'h005;
    localparam logic [11:0] CAL_HALF_SYMBOLS = 12'h00D;
    localparam int          CNT_W            = 12;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Sequencer states, Gray coded along the usual path.
    typedef enum logic [2:0] {
        SQ_IDLE     = 3'h0,
        SQ_RX_CAL   = 3'h1,
        SQ_RX_CHAIN = 3'h3,
        SQ_RX_ON    = 3'h2,
        SQ_TX_LEAD  = 3'h6,
        SQ_TX_ON    = 3'h7,
        SQ_TX_LAG   = 3'h5
    } rps_state_t;

    // Regulator power-on delay in microseconds for each code.
    function automatic logic [11:0] reg_delay_us(input logic [2:0] code);
        case (code)
            3'h0:    reg_delay_us = 12'h000;
            3'h1:    reg_delay_us = 12'h01F;
            3'h2:    reg_delay_us = 12'h03F;
            3'h3:    reg_delay_us = 12'h07D;
            3'h4:    reg_delay_us = 12'h0FA;
            3'h5:    reg_delay_us = 12'h1F4;
            3'h6:    reg_delay_us = 12'h3E8;
            default: reg_delay_us = 12'h7D0;
        endcase
    endfunction

endpackage

/* src/rps_us_timer.sv */
// Purpose: Microsecond tick and elapsed-microsecond counter with restart.
// Assumes: Restart is a one-cycle pulse or a level held while idle.
// Notes: The count saturates so long waits never wrap into a false match.
`timescale 1ns/1ps
module rps_us_timer
    import rps_pkg::*;
#(
    parameter int CYCLES = CYC_PER_US
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rst,
    // Control.
    input  wire logic             restart,
    // Elapsed time.
    output logic [CNT_W-1:0]      us_count
);
    localparam logic [7:0] LAST = 8'(CYCLES - 1);

    logic [7:0] pre_ff;

    initial begin
        if (CYCLES < 1 || CYCLES > 256) begin
            $error("rps_us_timer: CYCLES out of range");
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_ff <= 8'h00;
        end else if (restart || pre_ff == LAST) begin
            pre_ff <= 8'h00;
        end else begin
            pre_ff <= pre_ff + 8'h01;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            us_count <= '0;
        end else if (restart) begin
            us_count <= '0;
        end else if (pre_ff == LAST && us_count != '1) begin
            us_count <= us_count + 12'h001;
        end
    end

endmodule

/* src/rps_radio_power_seq.sv */
// Purpose: Regulator power-on delay, RX/TX lead and lag sequencing, manual masks.
// Assumes: rx_request and tx_request are levels, tx_last_chip a one-cycle pulse.
// Notes: Each analog line is registered; the AXI slave holds one write and one read.
// Notes on behaviour
// - Regulator off bit drives regulator power-down.
// - Read-only flag follows off bit after delay.
// - Flag at zero forces all analog power-down.
// - Three-bit code selects regulator power-on delay.
// - Demod and AGC wait after RX chain.
// - RX chain powers up together with filter calibration.
// - Switch rises programmed microseconds before transmit.
// - Amplifier powers up programmed lead before transmit.
// - Switch drops programmed time after last chip.
// - Amplifier and modulator stop after programmed lag.
// - Both amplifier paths off kills up-mixers.
// - Select picks LO or amplifier buffers.
// - Output-switch bias control feeds amplifier bias.
// - Active-low peak detector reset with mask.
// - Separate power-down line per analog block.
// - Reserved register bits read as zero.
`timescale 1ns/1ps
module rps_radio_power_seq
    import rps_pkg::*;
#(
    parameter int ADDR_W    = ADDR_BITS,
    parameter int SYMBOL_US = 16
) (
    // Clock and reset.
    input  wire logic              clk,
    input  wire logic              rst,
    // AXI4-Lite write address and data.
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read.
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Radio core requests.
    input  wire logic              rx_request,
    input  wire logic              tx_request,
    input  wire logic              tx_last_chip,
    // Regulator.
    output logic                   regulator_off,
    output logic                   delayed_radio_off_flag,
    // Sequencing strobes.
    output logic                   tx_enable,
    output logic                   modulator_enable,
    output logic                   demod_enable,
    output logic                   agc_enable,
    output logic                   rx_tx_switch_on,
    // Analog control lines.
    output logic                   gain_amp_reset_n,
    output logic                   global_bias_off,
    output logic                   output_switch_bias_ctl,
    output logic                   rxtx_select,
    output logic                   prescaler_off,
    output logic                   amp_neg_off,
    output logic                   amp_pos_off,
    output logic                   tx_converter_off,
    output logic                   up_mixer_off,
    output logic                   filter_cal_osc_off,
    output logic                   charge_pump_off,
    output logic                   synth_off,
    output logic                   rx_converter_off,
    output logic                   gain_amp_off,
    output logic                   bandpass_filter_off,
    output logic                   front_end_off
);
    initial begin
        if (ADDR_W < ADDR_BITS || ADDR_W > 32 || SYMBOL_US < 1 || SYMBOL_US > 256) begin
            $error("rps_radio_power_seq: parameter out of range");
        end
    end

    // Register selector shared by read and write decode.
    function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] addr);
        if (addr[1:0] != 2'h0 || addr[ADDR_W-1:2] > (ADDR_W-2)'(IDX_MASK_L)) begin
            reg_sel = 3'h0;
        end else begin
            case (addr[17:2])
                IDX_PWR:    reg_sel = 3'h1;
                IDX_TIM_H:  reg_sel = 3'h2;
                IDX_TIM_L:  reg_sel = 3'h3;
                IDX_MASK_H: reg_sel = 3'h4;
                IDX_MASK_L: reg_sel = 3'h5;
                default:    reg_sel = 3'h0;
            endcase
        end
    endfunction

    localparam logic [11:0] CAL_US = 12'((CAL_HALF_SYMBOLS * SYMBOL_US) / 2);

    // Software registers.
    logic              off_ff, flag_ff;
    logic [2:0]        code_ff;
    logic [7:0]        tim_h_ff, tim_l_ff, mask_h_ff;
    logic [6:0]        mask_l_ff;
    // Bus state.
    logic              aw_held_ff, w_held_ff, wlane_ff, do_write;
    logic [ADDR_W-1:0] awaddr_ff;
    logic [7:0]        wbyte_ff, rd_byte;
    logic [2:0]        wsel;
    // Sequencer.
    rps_state_t        state_ff, nxt_state;
    logic [CNT_W-1:0]  seq_us, reg_us;
    logic              seq_restart, reg_restart;
    logic [11:0]       rx_wait_us, sw_lead, amp_lead, lead_us, sw_lag, amp_lag, lag_us;
    logic              a_switch, a_amp, a_tx, a_rx_blocks, a_rx_on, a_synth, a_cal;

    // AXI write channel.
    assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_ff && !s_axi_bvalid;
    assign do_write      = aw_held_ff && w_held_ff && !s_axi_bvalid;
    assign wsel          = reg_sel(awaddr_ff);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_held_ff <= 1'b0;
            awaddr_ff  <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_ff <= 1'b1;
            awaddr_ff  <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            w_held_ff <= 1'b0;
            wbyte_ff  <= 8'h00;
            wlane_ff  <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_ff <= 1'b1;
            wbyte_ff  <= s_axi_wdata[7:0];
            wlane_ff  <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wsel == 3'h0) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Register writes; a missing low byte strobe leaves the register untouched.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            off_ff    <= RST_OFF;
            code_ff   <= RST_CODE;
            tim_h_ff  <= RST_TIM_H;
            tim_l_ff  <= RST_TIM_L;
            mask_h_ff <= RST_MASK_H;
            mask_l_ff <= RST_MASK_L;
        end else if (do_write && wlane_ff) begin
            case (wsel)
                3'h1: begin
                    off_ff  <= wbyte_ff[PWR_OFF_BIT];
                    code_ff <= wbyte_ff[PWR_CODE_LSB +: 3];
                end
                3'h2:    tim_h_ff  <= wbyte_ff;
                3'h3:    tim_l_ff  <= wbyte_ff;
                3'h4:    mask_h_ff <= wbyte_ff;
                3'h5:    mask_l_ff <= wbyte_ff[6:0];
                default: ;
            endcase
        end
    end

    // AXI read channel.
    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        case (reg_sel(s_axi_araddr))
            3'h1:    rd_byte = {3'h0, flag_ff, off_ff, code_ff};
            3'h2:    rd_byte = tim_h_ff;
            3'h3:    rd_byte = tim_l_ff;
            3'h4:    rd_byte = mask_h_ff;
            3'h5:    rd_byte = {1'b0, mask_l_ff};
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rd_byte};
            s_axi_rresp  <= (reg_sel(s_axi_araddr) == 3'h0) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Regulator delay: the wait restarts whenever the off bit and the flag agree.
    assign reg_restart = (off_ff == flag_ff);

    rps_us_timer u_reg_timer (.clk(clk), .rst(rst), .restart(reg_restart), .us_count(reg_us));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_ff <= RST_FLAG;
        end else if (!reg_restart && reg_us >= reg_delay_us(code_ff)) begin
            flag_ff <= off_ff;
        end
    end

    // Timing fields in microseconds.
    assign rx_wait_us = 12'(tim_h_ff[RXD_LSB +: 3] * RX_STEP_US);
    assign sw_lead    = {9'h000, tim_h_ff[SWL_LSB +: 3]};
    assign amp_lead   = {8'h00, tim_h_ff[AMPH_LSB +: 2], tim_l_ff[AMPL_LSB +: 2]};
    assign sw_lag     = {9'h000, tim_l_ff[SWG_LSB +: 3]};
    assign amp_lag    = {9'h000, tim_l_ff[AMPG_LSB +: 3]};
    assign lead_us    = (sw_lead > amp_lead) ? sw_lead : amp_lead;
    assign lag_us     = (sw_lag > amp_lag) ? sw_lag : amp_lag;

    // Sequencer: a new event restarts the shared microsecond count.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SQ_IDLE: begin
                if (tx_request) begin
                    nxt_state = SQ_TX_LEAD;
                end else if (rx_request) begin
                    nxt_state = SQ_RX_CAL;
                end
            end
            SQ_RX_CAL, SQ_RX_CHAIN, SQ_RX_ON: begin
                if (tx_request) begin
                    nxt_state = SQ_TX_LEAD;
                end else if (!rx_request) begin
                    nxt_state = SQ_IDLE;
                end else if (state_ff == SQ_RX_CAL && seq_us >= CAL_US) begin
                    nxt_state = SQ_RX_CHAIN;
                end else if (state_ff == SQ_RX_CHAIN && seq_us >= rx_wait_us) begin
                    nxt_state = SQ_RX_ON;
                end
            end
            SQ_TX_LEAD: begin
                if (seq_us >= lead_us) begin
                    nxt_state = SQ_TX_ON;
                end
            end
            SQ_TX_ON: begin
                if (tx_last_chip) begin
                    nxt_state = SQ_TX_LAG;
                end
            end
            SQ_TX_LAG: begin
                if (seq_us >= lag_us) begin
                    nxt_state = SQ_IDLE;
                end
            end
            default: nxt_state = SQ_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= SQ_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign seq_restart = (nxt_state != state_ff);

    rps_us_timer u_seq_timer (.clk(clk), .rst(rst), .restart(seq_restart), .us_count(seq_us));

    // Automatic values of each line before masking.
    always_comb begin
        a_switch = 1'b0;
        a_amp    = 1'b0;
        a_tx     = 1'b0;
        case (state_ff)
            SQ_TX_LEAD: begin
                a_switch = seq_us >= (lead_us - sw_lead);
                a_amp    = seq_us >= (lead_us - amp_lead);
            end
            SQ_TX_ON: begin
                a_switch = 1'b1;
                a_amp    = 1'b1;
                a_tx     = 1'b1;
            end
            SQ_TX_LAG: begin
                a_switch = seq_us < sw_lag;
                a_amp    = seq_us < amp_lag;
            end
            default: ;
        endcase
    end

    assign a_rx_blocks = (state_ff == SQ_RX_CAL) || (state_ff == SQ_RX_CHAIN) || (state_ff == SQ_RX_ON);
    assign a_rx_on     = (state_ff == SQ_RX_ON);
    assign a_cal       = (state_ff == SQ_RX_CAL);
    assign a_synth     = (state_ff != SQ_IDLE);

    // Registered outputs: strobes unmasked, other lines gated by their mask; only power-down lines are forced off by the flag.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {tx_enable, modulator_enable, demod_enable, agc_enable, rx_tx_switch_on} <= '0;
            {gain_amp_reset_n, output_switch_bias_ctl, rxtx_select} <= '0;
            {global_bias_off, prescaler_off, amp_neg_off, amp_pos_off, tx_converter_off} <= '1;
            {up_mixer_off, filter_cal_osc_off, charge_pump_off, synth_off, rx_converter_off} <= '1;
            {gain_amp_off, bandpass_filter_off, front_end_off} <= '1;
        end else begin
            tx_enable <= a_tx;
            modulator_enable <= a_amp;
            demod_enable <= a_rx_on;
            agc_enable <= a_rx_on;
            rx_tx_switch_on <= a_switch;
            gain_amp_reset_n <= a_rx_on & mask_h_ff[MH_VGARST];
            global_bias_off <= !flag_ff | (!a_synth & mask_h_ff[MH_BIAS]);
            output_switch_bias_ctl <= a_switch & mask_h_ff[MH_BALUN];
            rxtx_select <= a_switch & mask_h_ff[MH_RXTX];
            prescaler_off <= !flag_ff | (!a_synth & mask_h_ff[MH_PRE]);
            amp_neg_off <= !flag_ff | (!a_amp & mask_h_ff[MH_PAN]);
            amp_pos_off <= !flag_ff | (!a_amp & mask_h_ff[MH_PAP]);
            up_mixer_off <= !flag_ff | (!a_amp & mask_h_ff[MH_PAN] & mask_h_ff[MH_PAP]);
            tx_converter_off <= !flag_ff | (!a_amp & mask_h_ff[MH_DAC]);
            filter_cal_osc_off <= !flag_ff | (!a_cal & mask_l_ff[ML_CAL]);
            charge_pump_off <= !flag_ff | (!a_synth & mask_l_ff[ML_CHP]);
            synth_off <= !flag_ff | (!a_synth & mask_l_ff[ML_FS]);
            rx_converter_off <= !flag_ff | (!a_rx_blocks & mask_l_ff[ML_ADC]);
            gain_amp_off <= !flag_ff | (!a_rx_blocks & mask_l_ff[ML_VGA]);
            bandpass_filter_off <= !flag_ff | (!a_rx_blocks & mask_l_ff[ML_BPF]);
            front_end_off <= !flag_ff | (!a_rx_blocks & mask_l_ff[ML_LNA]);
        end
    end

    assign regulator_off          = off_ff;
    assign delayed_radio_off_flag = flag_ff;

endmodule

/* tb/rps_radio_power_seq_properties.sv */
// Purpose: Port checker for the radio power sequencer.
// Assumes: Lead and lag fields are nonzero while transmitting.
// Notes: Attached to the top module by the bind below.
`timescale 1ns/1ps
module rps_seq_properties (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Watched ports.
    input wire logic tx_last_chip,
    input wire logic regulator_off,
    input wire logic delayed_radio_off_flag,
    input wire logic tx_enable,
    input wire logic modulator_enable,
    input wire logic demod_enable,
    input wire logic agc_enable,
    input wire logic rx_tx_switch_on,
    input wire logic rxtx_select,
    input wire logic amp_neg_off,
    input wire logic amp_pos_off,
    input wire logic up_mixer_off,
    input wire logic front_end_off
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence lag_start;
        tx_last_chip && tx_enable;
    endsequence
    sequence lag_hold;
        ##2 !tx_enable && rx_tx_switch_on && modulator_enable;
    endsequence
    mixer_off_a: assert property (amp_neg_off && amp_pos_off |-> up_mixer_off)
        else $error("up mixers on with both amplifier paths off");
    flag_forces_a: assert property ($past(!delayed_radio_off_flag) && !delayed_radio_off_flag |-> front_end_off)
        else $error("front end on while flag low");
    flag_hold_a: assert property ($changed(regulator_off) |-> $stable(delayed_radio_off_flag))
        else $error("flag moved with no delay");
    demod_agc_a: assert property (demod_enable == agc_enable)
        else $error("demodulator and gain control differ");
    tx_on_a: assert property (tx_enable |-> rx_tx_switch_on && modulator_enable)
        else $error("transmit without switch or modulator");
    switch_lead_a: assert property ($rose(tx_enable) |-> $past(rx_tx_switch_on))
        else $error("switch not ahead of transmit");
    tx_lag_a: assert property (lag_start |-> lag_hold)
        else $error("lag outputs wrong after last chip");
    select_sw_a: assert property (rxtx_select |-> rx_tx_switch_on)
        else $error("buffer select without switch");
endmodule

bind rps_radio_power_seq rps_seq_properties i_props (.*);

/* tb/rps_core_model.sv */
// Purpose: Radio core stand-in that raises receive and transmit requests.
// Assumes: The bench gives rx_want and tx_want as levels.
// Notes: One last-chip pulse per packet of PKT cycles.
`timescale 1ns/1ps
module rps_core_model #(
    parameter int PKT = 60
) (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst,
    // Commands and transmit strobe.
    input  wire logic rx_want,
    input  wire logic tx_want,
    input  wire logic tx_enable,
    // Requests to the sequencer.
    output logic      rx_request,
    output logic      tx_request,
    output logic      tx_last_chip
);
    int cnt_ff;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_request <= 1'b0;
            tx_request <= 1'b0;
            tx_last_chip <= 1'b0;
            cnt_ff <= 0;
        end else begin
            rx_request <= rx_want;
            tx_last_chip <= 1'b0;
            if (!tx_enable) begin
                tx_request <= tx_want;
                cnt_ff <= 0;
            end else if (cnt_ff == PKT - 1) begin
                tx_last_chip <= 1'b1;
                tx_request <= 1'b0;
                cnt_ff <= cnt_ff + 1;
            end else if (cnt_ff < PKT) cnt_ff <= cnt_ff + 1;
        end
    end
endmodule

/* tb/tb_rps_radio_power_seq.sv */
// Purpose: Self-checking bench for the radio power sequencer.
// Assumes: SYMBOL_US is 2, so calibration lasts 13 us.
// Notes: Timing windows allow a few cycles for registered outputs.
`timescale 1ns/1ps
module tb_rps_radio_power_seq import rps_pkg::*; ;
    logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rx_request, tx_request, tx_last_chip;
    logic [17:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic regulator_off, delayed_radio_off_flag, tx_enable, modulator_enable, demod_enable, agc_enable;
    logic rx_tx_switch_on, gain_amp_reset_n, global_bias_off, output_switch_bias_ctl, rxtx_select, prescaler_off;
    logic amp_neg_off, amp_pos_off, tx_converter_off, up_mixer_off, filter_cal_osc_off, charge_pump_off, synth_off;
    logic rx_converter_off, gain_amp_off, bandpass_filter_off, front_end_off, rx_want, tx_want;
    int fail_count, checks, cyc, n, m;
    rps_radio_power_seq #(.SYMBOL_US(2)) i_dut (.*);
    rps_core_model i_core (.*);
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask
    task automatic near(input string nm, input int e, input int g);
        chk(nm, e, (g < e - 8 || g > e + 8) ? g : e);
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
        @(posedge clk);
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("write response", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask
    task automatic rd(input logic [15:0] idx, input logic [7:0] e, input logic [1:0] er);
        @(posedge clk);
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk("read response", {30'h0, er}, {30'h0, s_axi_rresp});
        if (er == RESP_OKAY) chk("read data", {24'h000000, e}, s_axi_rdata);
    endtask
    task automatic t_reset();
        chk("regulator off", 1'b1, regulator_off);
        chk("peak reset", 1'b0, gain_amp_reset_n);
        rd(IDX_PWR, 8'h1C, RESP_OKAY);
        rd(IDX_TIM_H, 8'h7A, RESP_OKAY);
        rd(IDX_TIM_L, 8'h94, RESP_OKAY);
        rd(IDX_MASK_H, 8'hFF, RESP_OKAY);
        rd(IDX_MASK_L, 8'h7F, RESP_OKAY);
        rd(16'h0001, 8'h00, RESP_SLVERR);
        wr(16'h0001, 8'h00, RESP_SLVERR);
    endtask
    task automatic t_masks();
        wr(IDX_MASK_L, 8'h00, RESP_OKAY);
        wr(IDX_MASK_H, 8'hF9, RESP_OKAY);
        repeat (3) @(posedge clk);
        chk("bandpass off", 1'b0, bandpass_filter_off);
        chk("up mixer off", 1'b0, up_mixer_off);
        wr(IDX_MASK_L, 8'h7F, RESP_OKAY);
        wr(IDX_MASK_H, 8'hFF, RESP_OKAY);
        repeat (3) @(posedge clk);
        chk("bandpass off", 1'b1, bandpass_filter_off);
        chk("up mixer off", 1'b1, up_mixer_off);
    endtask
    task automatic t_rx();
        rx_want <= 1'b1;
        repeat (12) @(posedge clk);
        chk("cal osc off", 1'b0, filter_cal_osc_off);
        n = 12;
        while (demod_enable !== 1'b1) begin
            @(posedge clk);
            n++;
        end
        near("receive delay", 1123, n);
        chk("peak reset", 1'b1, gain_amp_reset_n);
        rx_want <= 1'b0;
    endtask
    task automatic t_tx();
        tx_want <= 1'b1;
        while (rx_tx_switch_on !== 1'b1) @(posedge clk);
        chk("amp neg off", 1'b0, amp_neg_off);
        m = 0;
        while (tx_enable !== 1'b1) begin
            @(posedge clk);
            m++;
        end
        tx_want <= 1'b0;
        near("switch lead", 240, m);
        chk("select", 1'b1, rxtx_select);
        chk("switch bias", 1'b1, output_switch_bias_ctl);
        while (tx_last_chip !== 1'b1) @(posedge clk);
        n = 0;
        while (amp_neg_off !== 1'b1) begin
            @(posedge clk);
            n++;
            if (rx_tx_switch_on) m = n;
        end
        near("switch lag", 80, m);
        near("amp lag", 160, n);
    endtask
    task automatic t_regulator();
        wr(IDX_PWR, 8'hF1, RESP_OKAY);
        rd(IDX_PWR, 8'h11, RESP_OKAY);
        chk("regulator off", 1'b0, regulator_off);
        n = 0;
        while (delayed_radio_off_flag !== 1'b0) begin
            @(posedge clk);
            n++;
        end
        near("regulator delay", 1236, n);
        wr(IDX_MASK_L, 8'h00, RESP_OKAY);
        repeat (3) @(posedge clk);
        chk("front end off", 1'b1, front_end_off);
        wr(IDX_PWR, 8'h08, RESP_OKAY);
        repeat (6) @(posedge clk);
        chk("flag", 1'b1, delayed_radio_off_flag);
    endtask
    task automatic final_report();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // A hang in any wait loop ends here as a mismatch.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            final_report();
        end
    end
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        {fail_count, checks, cyc} = '0;
        {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
        {rx_want, tx_want, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_masks();
        t_rx();
        t_tx();
        t_regulator();
        final_report();
    end
endmodule
